// ---- rtl/multi_sensor_duty_cycle_logger.sv ----
// command interpreter, sequencer and hex reporter of the duty cycle logger
//
// Added by the designer: the address map and the Wishbone slave port.
module multi_sensor_duty_cycle_logger #(
  parameter int ON_CYC = logger_pkg::ON_CYC_DEF,
  parameter logic [35:0] RATE5_CYC = logger_pkg::RATE5_CYC_DEF,
  parameter logic [35:0] RATE20_CYC = logger_pkg::RATE20_CYC_DEF,
  parameter logic [35:0] RATE60_CYC = logger_pkg::RATE60_CYC_DEF,
  parameter logic [35:0] RATE600_CYC = logger_pkg::RATE600_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] sens_in,
  output logic [7:0] sens_pwr,
  output logic [2:0] mux_sel,
  output logic sup_5v,
  output logic scope_sync,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack
);
  logger_pkg::state_t state_r;
  logger_pkg::rate_t rate_r;
  logic [7:0] s1_r;
  logic [7:0] s2_r;
  logic [2:0] ch_r;
  logic [2:0] last_ch_r;
  logic cont_r;
  logic sup_5v_r;
  logic start_r;
  logic [6:0] idx_r;
  logic [7:0] tx_data_r;
  logic tx_valid_r;
  logic absent_r;
  logic [19:0] per_r;
  logic [35:0] num_r;
  logic [20:0] rem_r;
  logic [5:0] div_cnt_r;
  logic [35:0] wait_r;
  logic [7:0] sens_pwr_r;
  logic [2:0] mux_sel_r;
  logic sync_r;
  logic ack_r;
  logic [31:0] dat_r;

  meas_if mif ();

  duty_capture #(
    .ON_CYC(ON_CYC)
  ) u_capture (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .m(mif.cap)
  );

  // two flop synchronisers on the sensor pins
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!rst_b) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= sens_in[gi];
          s2_r[gi] <= s1_r[gi];
        end
      end
    end
  endgenerate

  assign mif.sig = s2_r[ch_r];
  assign mif.start = start_r;

  // command decode
  wire bus_req = wb_cyc & wb_stb & ~ack_r;
  wire bus_cmd = bus_req & wb_we & wb_sel[0] & (wb_adr == logger_pkg::CMD_OFS);
  wire cmd_valid = rx_valid | bus_cmd;
  wire [7:0] cmd = rx_valid ? rx_data : wb_dat_w[7:0];
  wire idle = (state_r == logger_pkg::ST_IDLE);
  wire is_digit = (cmd >= 8'h31) && (cmd <= 8'h38);
  wire go_help = cmd_valid & idle & (cmd == 8'h68);
  wire go_cont = cmd_valid & idle & (cmd == 8'h6D);
  wire go_one = cmd_valid & idle & is_digit;
  wire do_stop = cmd_valid & (cmd == 8'h73);
  wire [2:0] digit_ch = cmd[2:0] - 3'h1;
  wire tx_take = tx_valid_r & tx_ready;

  // divider step, quotient collects in the low bits of num_r
  wire [20:0] rem_sh = {rem_r[19:0], num_r[35]};
  wire div_ge = rem_sh >= {1'b0, per_r};
  wire [20:0] rem_new = div_ge ? rem_sh - {1'b0, per_r} : rem_sh;
  wire [35:0] num_new = {num_r[34:0], div_ge};

  // report values and line character
  wire [15:0] hi_val = absent_r ? logger_pkg::ABSENT_VAL : num_r[15:0];
  wire [15:0] pe_val = absent_r ? logger_pkg::ABSENT_VAL : logger_pkg::FULL_SCALE;
  wire [3:0] lidx = idx_r[3:0];
  wire [3:0] hi_nib = hi_val[4'(4'h3 - lidx[1:0]) * 4 +: 4];
  wire [3:0] pe_nib = pe_val[4'(4'h3 - (lidx[1:0] - 2'h1)) * 4 +: 4];
  wire [7:0] line_ch = (lidx < 4'h4) ? hexc(hi_nib) :
                       (lidx == 4'h4) ? logger_pkg::CH_SP :
                       (lidx < 4'h9) ? hexc(pe_nib) :
                       (lidx == 4'h9) ? logger_pkg::CH_CR : logger_pkg::CH_LF;
  wire [7:0] help_ch =
    logger_pkg::HELP_TXT[(logger_pkg::HELP_LEN - 1 - int'(idx_r)) * 8 +: 8];
  wire line_end = tx_take & (lidx == logger_pkg::LINE_LAST);
  wire help_end = tx_take & (idx_r == logger_pkg::HELP_LAST);

  wire [35:0] wait_load = (rate_r == logger_pkg::RATE_5S) ? RATE5_CYC :
                          (rate_r == logger_pkg::RATE_20S) ? RATE20_CYC :
                          (rate_r == logger_pkg::RATE_60S) ? RATE60_CYC :
                          (rate_r == logger_pkg::RATE_10M) ? RATE600_CYC : 36'h0;

  function automatic logic [7:0] hexc(input logic [3:0] n);
    hexc = (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction : hexc

  // settings held between passes
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rate_r <= logger_pkg::rate_t'(logger_pkg::RATE_RST);
      sup_5v_r <= logger_pkg::SUP_RST;
    end else if (cmd_valid) begin
      case (cmd)
        8'h21: rate_r <= logger_pkg::RATE_CONT;
        8'h40: rate_r <= logger_pkg::RATE_5S;
        8'h23: rate_r <= logger_pkg::RATE_20S;
        8'h24: rate_r <= logger_pkg::RATE_60S;
        8'h25: rate_r <= logger_pkg::RATE_10M;
        8'h76: sup_5v_r <= 1'b0;
        8'h56: sup_5v_r <= 1'b1;
        default: rate_r <= rate_r;
      endcase
    end
  end

  // sequencer
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_r <= logger_pkg::ST_IDLE;
      ch_r <= 3'h0;
      last_ch_r <= 3'h0;
      cont_r <= 1'b0;
      start_r <= 1'b0;
      wait_r <= 36'h0;
    end else begin
      start_r <= 1'b0;
      if (do_stop) begin
        cont_r <= 1'b0;
      end
      case (state_r)
        logger_pkg::ST_IDLE: begin
          if (go_help) begin
            state_r <= logger_pkg::ST_HELP;
          end else if (go_cont || go_one) begin
            state_r <= logger_pkg::ST_CAPT;
            ch_r <= 3'h0;
            last_ch_r <= go_one ? digit_ch : 3'h7;
            cont_r <= go_cont;
            start_r <= 1'b1;
          end
        end
        logger_pkg::ST_HELP: begin
          if (help_end) begin
            state_r <= logger_pkg::ST_IDLE;
          end
        end
        logger_pkg::ST_CAPT: begin
          if (mif.done) begin
            state_r <= logger_pkg::ST_DIV;
          end
        end
        logger_pkg::ST_DIV: begin
          if (div_cnt_r == logger_pkg::DIV_LAST) begin
            state_r <= logger_pkg::ST_SEND;
          end
        end
        logger_pkg::ST_SEND: begin
          if (line_end && ch_r != last_ch_r) begin
            state_r <= logger_pkg::ST_CAPT;
            ch_r <= ch_r + 3'h1;
            start_r <= 1'b1;
          end else if (line_end && cont_r && !do_stop) begin
            state_r <= logger_pkg::ST_WAIT;
            wait_r <= wait_load;
          end else if (line_end) begin
            state_r <= logger_pkg::ST_IDLE;
          end
        end
        logger_pkg::ST_WAIT: begin
          if (!cont_r || do_stop) begin
            state_r <= logger_pkg::ST_IDLE;
          end else if (wait_r == 36'h0) begin
            state_r <= logger_pkg::ST_CAPT;
            ch_r <= 3'h0;
            start_r <= 1'b1;
          end else begin
            wait_r <= wait_r - 36'h1;
          end
        end
        default: state_r <= logger_pkg::ST_IDLE;
      endcase
    end
  end

  // capture result and scaling divide
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      absent_r <= 1'b0;
      per_r <= 20'h00000;
      num_r <= 36'h0;
      rem_r <= 21'h000000;
      div_cnt_r <= 6'h00;
    end else if (state_r == logger_pkg::ST_CAPT && mif.done) begin
      absent_r <= mif.absent | (mif.period_count == 20'h00000);
      per_r <= mif.period_count;
      num_r <= 36'(mif.high_time_count) * 36'(logger_pkg::FULL_SCALE);
      rem_r <= 21'h000000;
      div_cnt_r <= 6'h00;
    end else if (state_r == logger_pkg::ST_DIV) begin
      num_r <= num_new;
      rem_r <= rem_new;
      div_cnt_r <= div_cnt_r + 6'h01;
    end
  end

  // character transmitter
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
      idx_r <= 7'h00;
    end else if (go_help || state_r == logger_pkg::ST_DIV) begin
      idx_r <= 7'h00;
    end else if (tx_take) begin
      tx_valid_r <= 1'b0;
      idx_r <= idx_r + 7'h01;
    end else if (!tx_valid_r && state_r == logger_pkg::ST_HELP) begin
      tx_valid_r <= 1'b1;
      tx_data_r <= help_ch;
    end else if (!tx_valid_r && state_r == logger_pkg::ST_SEND) begin
      tx_valid_r <= 1'b1;
      tx_data_r <= line_ch;
    end
  end

  // sensor supply, selector and scope sync
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sens_pwr_r <= 8'h00;
      mux_sel_r <= 3'h0;
      sync_r <= 1'b0;
    end else begin
      sens_pwr_r <= (state_r == logger_pkg::ST_CAPT) ? 8'h01 << ch_r : 8'h00;
      mux_sel_r <= ch_r;
      sync_r <= (state_r == logger_pkg::ST_CAPT) && (ch_r == 3'h0) && mif.counting &&
                (mif.per_idx < logger_pkg::SYNC_PER);
    end
  end

  // wishbone slave, one wait state, unmapped reads return zero
  wire [31:0] rd_val = (wb_adr == logger_pkg::CMD_OFS) ?
                         {27'h0, cont_r, sup_5v_r, rate_r} :
                       (wb_adr == logger_pkg::STAT_OFS) ?
                         {23'h0, absent_r, mif.counting, ch_r, state_r, ~idle} : 32'h0;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= bus_req;
      dat_r <= (bus_req && !wb_we) ? rd_val : 32'h0;
    end
  end

  assign tx_data = tx_data_r;
  assign tx_valid = tx_valid_r;
  assign sens_pwr = sens_pwr_r;
  assign mux_sel = mux_sel_r;
  assign sup_5v = sup_5v_r;
  assign scope_sync = sync_r;
  assign wb_ack = ack_r;
  assign wb_dat_r = dat_r;
endmodule : multi_sensor_duty_cycle_logger

// ---- rtl/logger_pkg.sv ----
// constants, codes and states shared by the duty cycle logger
package logger_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int SENSOR_ON_MS = 10;
  localparam int ON_CYC_DEF = SENSOR_ON_MS * (CLK_HZ / 1000);
  localparam int RATE5_S = 5;
  localparam int RATE20_S = 20;
  localparam int RATE60_S = 60;
  localparam int RATE600_S = 600;
  localparam logic [35:0] RATE5_CYC_DEF = 36'(RATE5_S) * 36'(CLK_HZ);
  localparam logic [35:0] RATE20_CYC_DEF = 36'(RATE20_S) * 36'(CLK_HZ);
  localparam logic [35:0] RATE60_CYC_DEF = 36'(RATE60_S) * 36'(CLK_HZ);
  localparam logic [35:0] RATE600_CYC_DEF = 36'(RATE600_S) * 36'(CLK_HZ);
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [2:0] RATE_RST = 3'h0;
  localparam logic SUP_RST = 1'b0;
  localparam logic [4:0] PER_CAPT = 5'h10;
  localparam logic [4:0] SYNC_PER = 5'h08;
  localparam logic [3:0] LINE_LAST = 4'hA;
  localparam logic [5:0] DIV_LAST = 6'h23;
  localparam logic [15:0] FULL_SCALE = 16'hFFFE;
  localparam logic [15:0] ABSENT_VAL = 16'hFFFF;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam int HELP_LEN = 67;
  localparam logic [6:0] HELP_LAST = 7'h42;
  localparam logic [8*HELP_LEN-1:0] HELP_TXT = {"DUTY CYCLE LOGGER", CH_CR, CH_LF,
    "h m s ! @ # $ % 1-8 v V", CH_CR, CH_LF, "Please Make a Choice:", CH_CR, CH_LF};
  typedef enum logic [2:0] {
    RATE_CONT = 3'b000,
    RATE_5S = 3'b001,
    RATE_20S = 3'b010,
    RATE_60S = 3'b011,
    RATE_10M = 3'b100
  } rate_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HELP = 3'b001,
    ST_CAPT = 3'b010,
    ST_DIV = 3'b011,
    ST_SEND = 3'b100,
    ST_WAIT = 3'b101
  } state_t;
endpackage : logger_pkg

// ---- rtl/meas_if.sv ----
// handshake between the sequencer and the period capture unit
interface meas_if;
  logic start;
  logic sig;
  logic done;
  logic absent;
  logic counting;
  logic [4:0] per_idx;
  logic [19:0] high_time_count;
  logic [19:0] period_count;
  modport ctl (output start, output sig, input done, input absent, input counting,
    input per_idx, input high_time_count, input period_count);
  modport cap (input start, input sig, output done, output absent, output counting,
    output per_idx, output high_time_count, output period_count);
endinterface : meas_if

// ---- rtl/duty_capture.sv ----
// sums high time and period over sixteen sensor periods
module duty_capture #(
  parameter int ON_CYC = logger_pkg::ON_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  meas_if.cap m
);
  logic sig_d_r;
  logic run_r;
  logic armed_r;
  logic done_r;
  logic absent_r;
  logic [19:0] tout_r;
  logic [4:0] idx_r;
  logic [19:0] hi_r;
  logic [19:0] per_r;
  wire rise = m.sig & ~sig_d_r;
  wire tout_hit = run_r & (tout_r == 20'(ON_CYC - 1));
  wire last_rise = run_r & armed_r & rise & (idx_r == logger_pkg::PER_CAPT - 5'h01);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sig_d_r <= 1'b0;
      run_r <= 1'b0;
      armed_r <= 1'b0;
      done_r <= 1'b0;
      absent_r <= 1'b0;
      tout_r <= 20'h00000;
      idx_r <= 5'h00;
      hi_r <= 20'h00000;
      per_r <= 20'h00000;
    end else begin
      sig_d_r <= m.sig;
      done_r <= 1'b0;
      if (m.start) begin
        run_r <= 1'b1;
        armed_r <= 1'b0;
        absent_r <= 1'b0;
        tout_r <= 20'h00000;
        idx_r <= 5'h00;
        hi_r <= 20'h00000;
        per_r <= 20'h00000;
      end else if (tout_hit) begin
        run_r <= 1'b0;
        armed_r <= 1'b0;
        done_r <= 1'b1;
        absent_r <= 1'b1;
      end else if (last_rise) begin
        run_r <= 1'b0;
        armed_r <= 1'b0;
        done_r <= 1'b1;
      end else if (run_r) begin
        tout_r <= tout_r + 20'h00001;
        if (rise) begin
          armed_r <= 1'b1;
        end
        if (rise && armed_r) begin
          idx_r <= idx_r + 5'h01;
        end
        if (armed_r || rise) begin
          per_r <= per_r + 20'h00001;
          hi_r <= hi_r + {19'h00000, m.sig};
        end
      end
    end
  end

  assign m.done = done_r;
  assign m.absent = absent_r;
  assign m.counting = run_r & armed_r;
  assign m.per_idx = idx_r;
  assign m.high_time_count = hi_r;
  assign m.period_count = per_r;
endmodule : duty_capture

// ---- bench/logger_assertions.sv ----
// port assertions for the duty cycle logger
module logger_assertions #(
  parameter int ON_CYC = logger_pkg::ON_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] sens_pwr,
  input wire logic [2:0] mux_sel,
  input wire logic sup_5v,
  input wire logic scope_sync,
  input wire logic wb_cyc,
  input wire logic wb_stb
);
  timeunit 1ns;
  timeprecision 1ns;
  int on_cnt_r;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // cycles the current sensor has been powered
  always_ff @(posedge core_clk) begin
    if (!rst_b || sens_pwr == 8'h00) begin
      on_cnt_r <= 0;
    end else begin
      on_cnt_r <= on_cnt_r + 1;
    end
  end
  a_pwr_one_hot: assert property ($onehot0(sens_pwr))
    else $error("several sensors powered");
  a_pwr_time_bound: assert property (on_cnt_r <= ON_CYC + 4)
    else $error("sensor powered too long");
  a_mux_follows_pwr: assert property (sens_pwr != 8'h00 |-> sens_pwr == (8'h01 << mux_sel))
    else $error("selector and supply disagree");
  a_quiet_capture: assert property (sens_pwr != 8'h00 |-> !tx_valid)
    else $error("text sent during capture");
  a_sync_ch_one: assert property (scope_sync |-> sens_pwr == 8'h01)
    else $error("sync outside channel one");
  a_tx_hold_data: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte dropped before acceptance");
  a_tx_idle_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("no gap after accepted byte");
  a_supply_high: assert property (rx_valid && rx_data == 8'h56 |=> sup_5v)
    else $error("supply not raised");
  a_supply_kept: assert property (!(rx_valid || (wb_cyc && wb_stb)) |=> $stable(sup_5v))
    else $error("supply changed without command");
  cover property (scope_sync);
  cover property (tx_valid && tx_ready && tx_data == 8'h0A);
  cover property (sens_pwr == 8'h80);
endmodule : logger_assertions

bind multi_sensor_duty_cycle_logger logger_assertions #(.ON_CYC(ON_CYC)) logger_assertions_i (
  .core_clk(core_clk), .rst_b(rst_b), .rx_data(rx_data), .rx_valid(rx_valid),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .sens_pwr(sens_pwr),
  .mux_sel(mux_sel), .sup_5v(sup_5v), .scope_sync(scope_sync), .wb_cyc(wb_cyc),
  .wb_stb(wb_stb)
);

// ---- bench/host_term.sv ----
// terminal sink model that accepts or stalls the text stream
module host_term (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic slow,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lfsr_r;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      lfsr_r <= 8'h5A;
      tx_ready <= 1'b0;
    end else begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      tx_ready <= slow ? (lfsr_r[0] & lfsr_r[2]) : 1'b1;
    end
  end
endmodule : host_term

// ---- bench/testbench.sv ----
// self-checking bench for the duty cycle logger
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ON_CYC = 2000;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic rx_valid = 1'b0;
  logic [7:0] sens_in = 8'h00;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h00000000;
  logic slow = 1'b0;
  logic [7:0] tx_data, sens_pwr;
  logic [2:0] mux_sel;
  logic tx_valid, tx_ready, sup_5v, scope_sync, wb_ack;
  logic [31:0] wb_dat_r, rd;
  logic [7:0] exp_q[$];
  logic [7:0] rate_ch[5] = '{8'h21, 8'h40, 8'h23, 8'h24, 8'h25};
  logic [31:0] seed = 32'h0000AF85;
  int digs[3] = '{1, 3, 8};
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  int hi[8], per[8], cnt[8];
  int sync_cnt = 0;
  int s0;

  multi_sensor_duty_cycle_logger #(.ON_CYC(ON_CYC), .RATE5_CYC(36'h032))
    multi_sensor_duty_cycle_logger_i (
    .core_clk(core_clk), .rst_b(rst_b), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .sens_in(sens_in),
    .sens_pwr(sens_pwr), .mux_sel(mux_sel), .sup_5v(sup_5v), .scope_sync(scope_sync),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));
  host_term host_term_i (.core_clk(core_clk), .rst_b(rst_b), .slow(slow), .tx_ready(tx_ready));

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // powered sensors restart their wave at power-on, pull-down otherwise, channel 8 absent
  always @(posedge core_clk) begin
    for (int i = 0; i < 8; i++) begin
      cnt[i] <= (sens_pwr[i] !== 1'b1 || cnt[i] + 1 >= per[i]) ? 0 : cnt[i] + 1;
      sens_in[i] <= sens_pwr[i] === 1'b1 && i < 7 && cnt[i] < hi[i];
    end
  end

  // cycles the scope sync pin stands high
  always @(posedge core_clk) begin
    if (scope_sync === 1'b1) begin
      sync_cnt <= sync_cnt + 1;
    end
  end

  always @(posedge core_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      total_checks++;
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("unexpected at %0t: extra byte %h", $time, tx_data);
      end else if (tx_data !== exp_q[0]) begin
        n_mismatch++;
        $display("unexpected at %0t: byte %h want %h", $time, tx_data, exp_q[0]);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_mismatch++;
      $display("unexpected at %0t: timeout", $time);
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
    total_checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask : chk

  task automatic send(input logic [7:0] c);
    @(posedge core_clk);
    rx_data <= c;
    rx_valid <= 1'b1;
    @(posedge core_clk);
    rx_valid <= 1'b0;
  endtask : send

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    seed = xs(seed);
    wb_sel <= we ? 4'hF : seed[3:0];
    wb_dat_w <= dat;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    chk(32'(n), 32'h00000002, "bus answer");
  endtask : wb_xfer

  task automatic push_hex(input logic [15:0] v);
    logic [3:0] d;
    for (int k = 3; k >= 0; k--) begin
      d = v[4*k +: 4];
      exp_q.push_back(d < 4'hA ? 8'h30 + 8'(d) : 8'h37 + 8'(d));
    end
  endtask : push_hex

  task automatic push_pass(input int n);
    for (int i = 0; i < n; i++) begin
      push_hex(i == 7 ? 16'hFFFF : 16'((longint'(hi[i]) * 65534) / per[i]));
      exp_q.push_back(8'h20);
      push_hex(i == 7 ? 16'hFFFF : 16'hFFFE);
      exp_q.push_back(8'h0D);
      exp_q.push_back(8'h0A);
    end
  endtask : push_pass

  task automatic drain(input string name);
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 40000) begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(exp_q.size()), 32'h00000000, "bytes missing");
    $display("test %s done", name);
  endtask : drain

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  initial begin
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      per[i] = 20 + int'(seed[5:0]);
      hi[i] = 1 + int'(seed[13:8]) % (per[i] - 1);
    end
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = logger_pkg::HELP_LEN - 1; i >= 0; i--) begin
      exp_q.push_back(logger_pkg::HELP_TXT[8*i +: 8]);
    end
    send(8'h68);
    drain("help");
    for (int r = 0; r < 5; r++) begin
      send(rate_ch[r]);
      wb_xfer(1'b0, logger_pkg::CMD_OFS, 32'h00000000);
      chk(rd & 32'h00000007, 32'(r), "rate");
    end
    send(8'h56);
    send(8'h78);
    wb_xfer(1'b1, logger_pkg::CMD_OFS, 32'h00000071);
    wb_xfer(1'b0, logger_pkg::CMD_OFS, 32'h00000000);
    chk(rd, 32'h0000000C, "unknown kept settings");
    chk(32'(sup_5v), 32'h00000001, "supply pin high");
    wb_xfer(1'b1, logger_pkg::CMD_OFS, 32'h00000076);
    send(8'h40);
    wb_xfer(1'b0, logger_pkg::CMD_OFS, 32'h00000000);
    chk(rd, 32'h00000001, "supply low");
    chk(32'(sup_5v), 32'h00000000, "supply pin low");
    wb_xfer(1'b0, 8'h40, 32'h00000000);
    chk(rd, 32'h00000000, "unmapped read");
    $display("test settings done");
    for (int j = 0; j < 3; j++) begin
      slow <= (j > 0);
      push_pass(digs[j]);
      s0 = sync_cnt;
      send(8'h30 + 8'(digs[j]));
      send(8'h68);
      drain("single pass");
      chk(32'(sync_cnt - s0), 32'(8 * per[0]), "sync span");
    end
    push_pass(8);
    push_pass(8);
    send(8'h6D);
    drain("continuous");
    send(8'h73);
    repeat (3000) @(posedge core_clk);
    wb_xfer(1'b0, logger_pkg::STAT_OFS, 32'h00000000);
    chk(rd & 32'h0000000F, 32'h00000000, "idle after stop");
    $display("test stop done");
    conclude();
  end
endmodule : testbench
